// [conv_model.sv]
`timescale 1ns/1ps

// Converter stand-in: one-cycle sample strobe, lines scrambled outside it
module conv_model
    import remote_temp_pkg::*;
(
    input  wire logic                                   clk_sys,
    output logic                                        conv_valid,
    output logic [remote_temp_pkg::SIGNED_W-1:0]        conv_signed,
    output logic [remote_temp_pkg::UNSIGNED_W-1:0]      conv_unsigned
);
    initial
    begin
        conv_valid    = 1'b0;
        conv_signed   = '0;
        conv_unsigned = '0;
    end

    // Inverted data after the strobe catches a design that samples late
    task automatic sample(input logic [SIGNED_W-1:0] s, input logic [UNSIGNED_W-1:0] u);
        @(posedge clk_sys);
        conv_valid    <= 1'b1;
        conv_signed   <= s;
        conv_unsigned <= u;
        @(posedge clk_sys);
        conv_valid    <= 1'b0;
        conv_signed   <= ~s;
        conv_unsigned <= ~u;
    endtask
endmodule

// [masked_byte_reg.sv]
`timescale 1ns/1ps

// Byte register whose unimplemented bits never store and read as zero
module masked_byte_reg #(
    parameter logic [7:0] WMASK     = 8'hff,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] value
);

    logic [7:0] value_r;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            value_r <= RESET_VAL & WMASK;
        else if (wr_en)
            value_r <= wr_data & WMASK;
    end

    assign value = value_r;

endmodule

// [remote_temp_asserts.sv]
`timescale 1ns/1ps

module remote_temp_asserts
    import remote_temp_pkg::*;
(
    input  wire logic                                   clk_sys,
    input  wire logic                                   reset,
    input  wire logic                                   conv_valid,
    input  wire logic [remote_temp_pkg::SIGNED_W-1:0]   signed_reading,
    input  wire logic                                   filter_enable,
    input  wire logic                                   s_axi_awvalid,
    input  wire logic                                   s_axi_awready,
    input  wire logic                                   s_axi_wvalid,
    input  wire logic                                   s_axi_wready,
    input  wire logic                                   s_axi_bvalid,
    input  wire logic [remote_temp_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                                   s_axi_arvalid,
    input  wire logic                                   s_axi_arready,
    input  wire logic [remote_temp_pkg::AXI_DATA_W-1:0] s_axi_rdata,
    input  wire logic                                   s_axi_rvalid,
    input  wire logic                                   s_axi_rready
);
    logic [AXI_ADDR_W-1:0] rd_addr_r;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Remember which register the pending read answers for
    always_ff @(posedge clk_sys)
    begin
        if (s_axi_arvalid && s_axi_arready)
            rd_addr_r <= s_axi_araddr;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence answer_after_commit;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    a_reset_clears: assert property (@(posedge clk_sys) disable iff (1'b0)
        reset |=> signed_reading == '0 && !filter_enable) else $error("reset left state");
    a_write_answer: assert property (aw_w_taken |=> answer_after_commit)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_reading_holds: assert property (!$past(conv_valid) && !$past(reset) |->
        $stable(signed_reading)) else $error("reading moved without sample");
    a_unused_low: assert property (s_axi_rvalid && rd_addr_r == {IDX_UNSIGNED_LOW, 2'b00}
        |-> s_axi_rdata[2:0] == 3'h0) else $error("unused low bits set");
    a_filter_off_zero: assert property (s_axi_rvalid && !filter_enable &&
        rd_addr_r == {IDX_UNSIGNED_LOW, 2'b00} |-> s_axi_rdata[4:3] == 2'h0)
        else $error("extended bits set with filter off");
    a_offset_low_zero: assert property (s_axi_rvalid && rd_addr_r == {IDX_OFFSET_LOW, 2'b00}
        |-> s_axi_rdata[4:0] == 5'h00) else $error("offset low reserved bits set");
    a_signed_high: assert property (s_axi_rvalid && rd_addr_r == {IDX_SIGNED_HIGH, 2'b00}
        |-> s_axi_rdata[7:0] == signed_reading[10:3]) else $error("signed high mismatch");
endmodule

bind remote_temp_offset_and_format remote_temp_asserts chk_u (
    .clk_sys(clk_sys), .reset(reset), .conv_valid(conv_valid),
    .signed_reading(signed_reading), .filter_enable(filter_enable),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// [remote_temp_offset_and_format.sv]
`timescale 1ns/1ps

// Contract
// - Unsigned low byte fraction sits in bits 7:3
// - Filter off: unsigned low bits 1:0 zero
// - Filter on: bits 1:0 weigh 1/16, 1/32
// - Unused unsigned low bits always read zero
// - Signed reading equals converter output plus offset, clipped at either limit
// - Offset is signed, raises or lowers reading
// - Offset layout matches signed reading, filter off
// - Offset bytes read/write, zero after reset
// - Offset low bits 4:0 ignore writes, read zero
// - Unsigned high byte: bit7 128, down to 1
// - Signed high byte: bit7 sign, bit6 64
module remote_temp_offset_and_format
    import remote_temp_pkg::*;
(
    input  wire logic                                        clk_sys,
    input  wire logic                                        reset,
    // Converter side, same clock domain
    input  wire logic                                        conv_valid,
    input  wire logic [remote_temp_pkg::SIGNED_W-1:0]        conv_signed,
    input  wire logic [remote_temp_pkg::UNSIGNED_W-1:0]      conv_unsigned,
    output logic      [remote_temp_pkg::SIGNED_W-1:0]        signed_reading,
    output logic                                             filter_enable,
    // AXI4-Lite slave
    input  wire logic [remote_temp_pkg::AXI_ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                                        s_axi_awvalid,
    output logic                                             s_axi_awready,
    input  wire logic [remote_temp_pkg::AXI_DATA_W-1:0]      s_axi_wdata,
    input  wire logic [remote_temp_pkg::AXI_STRB_W-1:0]      s_axi_wstrb,
    input  wire logic                                        s_axi_wvalid,
    output logic                                             s_axi_wready,
    output logic      [1:0]                                  s_axi_bresp,
    output logic                                             s_axi_bvalid,
    input  wire logic                                        s_axi_bready,
    input  wire logic [remote_temp_pkg::AXI_ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                                        s_axi_arvalid,
    output logic                                             s_axi_arready,
    output logic      [remote_temp_pkg::AXI_DATA_W-1:0]      s_axi_rdata,
    output logic      [1:0]                                  s_axi_rresp,
    output logic                                             s_axi_rvalid,
    input  wire logic                                        s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic                    aw_held_r;
    logic                    aw_held_nxt;
    logic [IDX_W-1:0]        aw_idx_r;
    logic                    w_held_r;
    logic                    w_held_nxt;
    logic [7:0]              w_byte_r;
    logic                    w_lane0_r;
    logic                    awready_r;
    logic                    wready_r;
    logic                    bvalid_r;
    logic                    bvalid_nxt;
    logic [1:0]              bresp_r;
    logic                    arready_r;
    logic                    rvalid_r;
    logic                    rvalid_nxt;
    logic [1:0]              rresp_r;
    logic [AXI_DATA_W-1:0]   rdata_r;
    logic                    aw_take;
    logic                    w_take;
    logic                    ar_take;
    logic                    commit;
    logic                    wr_hit;
    logic                    wr_offset_high;
    logic                    wr_offset_low;
    logic                    wr_control;
    logic [IDX_W-1:0]        ar_idx;
    logic [7:0]              rd_byte;
    logic                    rd_hit;

    logic [7:0]              offset_integer_bits;
    logic [7:0]              offset_low_byte;
    logic [2:0]              offset_fraction_bits;
    logic [SIGNED_W-1:0]     offset_full;
    logic [SUM_W-1:0]        sum_wide;
    logic [SIGNED_W-1:0]     sum_sat;
    logic                    sum_clipped;

    logic [SIGNED_W-1:0]     signed_r;
    logic [UNSIGNED_W-1:0]   unsigned_r;
    logic                    filter_r;
    logic                    sampled_r;
    logic                    sat_r;
    logic [7:0]              signed_remote_integer_bits;
    logic [7:0]              unsigned_remote_integer_bits;
    logic [4:0]              unsigned_remote_fraction_bits;
    logic [7:0]              unsigned_low_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel handshakes

    assign aw_take = s_axi_awvalid & awready_r;
    assign w_take  = s_axi_wvalid & wready_r;
    assign commit  = aw_held_r & w_held_r & ~bvalid_r;

    always_comb
    begin
        aw_held_nxt = aw_held_r;
        w_held_nxt  = w_held_r;
        bvalid_nxt  = bvalid_r;
        if (aw_take)
            aw_held_nxt = 1'b1;
        if (w_take)
            w_held_nxt = 1'b1;
        if (commit)
        begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
        end
        else if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
    end

    // Address and data may arrive in either order; each is held until both exist
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            aw_idx_r  <= '0;
            w_byte_r  <= 8'h00;
            w_lane0_r <= 1'b0;
        end
        else
        begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awready_r <= ~aw_held_nxt & ~bvalid_nxt;
            wready_r  <= ~w_held_nxt & ~bvalid_nxt;
            if (aw_take)
                aw_idx_r <= s_axi_awaddr[AXI_ADDR_W-1:2];
            if (w_take)
            begin
                w_byte_r  <= s_axi_wdata[7:0];
                w_lane0_r <= s_axi_wstrb[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    always_comb
    begin
        wr_hit = 1'b1;
        unique case (aw_idx_r)
            IDX_SIGNED_HIGH,
            IDX_OFFSET_HIGH,
            IDX_OFFSET_LOW,
            IDX_UNSIGNED_HIGH,
            IDX_UNSIGNED_LOW,
            IDX_CONTROL,
            IDX_STATUS:        wr_hit = 1'b1;
            default:           wr_hit = 1'b0;
        endcase
    end

    // Writes without lane 0 complete normally but change nothing
    assign wr_offset_high = commit & w_lane0_r & (aw_idx_r == IDX_OFFSET_HIGH);
    assign wr_offset_low  = commit & w_lane0_r & (aw_idx_r == IDX_OFFSET_LOW);
    assign wr_control     = commit & w_lane0_r & (aw_idx_r == IDX_CONTROL);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end
        else
        begin
            bvalid_r <= bvalid_nxt;
            if (commit)
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offset registers

    // Bits 4:0 of the low byte never store, so they read back zero
    masked_byte_reg #(
        .WMASK     (OFFSET_HIGH_MASK),
        .RESET_VAL (OFFSET_HIGH_RESET)
    ) offset_high_reg (
        .clk_sys (clk_sys),
        .reset   (reset),
        .wr_en   (wr_offset_high),
        .wr_data (w_byte_r),
        .value   (offset_integer_bits)
    );

    masked_byte_reg #(
        .WMASK     (OFFSET_LOW_MASK),
        .RESET_VAL (OFFSET_LOW_RESET)
    ) offset_low_reg (
        .clk_sys (clk_sys),
        .reset   (reset),
        .wr_en   (wr_offset_low),
        .wr_data (w_byte_r),
        .value   (offset_low_byte)
    );

    assign offset_fraction_bits = offset_low_byte[7:OFFSET_FRAC_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // Offset addition

    // Both operands are 8.3, so fractions line up without shifting
    assign offset_full = {offset_integer_bits, offset_fraction_bits};

    // One guard bit catches overflow; the result clips rather than wraps,
    // so a large correction cannot flip a hot reading to a cold one
    assign sum_wide = {conv_signed[SIGNED_W-1], conv_signed}
                    + {offset_full[SIGNED_W-1], offset_full};

    always_comb
    begin
        sum_clipped = 1'b0;
        sum_sat     = sum_wide[SIGNED_W-1:0];
        if (sum_wide[SUM_W-1] != sum_wide[SIGNED_W-1])
        begin
            sum_clipped = 1'b1;
            sum_sat     = sum_wide[SUM_W-1] ? SIGNED_MIN : SIGNED_MAX;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reading capture and control

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            signed_r   <= '0;
            unsigned_r <= '0;
            sampled_r  <= 1'b0;
            sat_r      <= 1'b0;
        end
        else if (conv_valid)
        begin
            signed_r   <= sum_sat;
            unsigned_r <= conv_unsigned;
            sampled_r  <= 1'b1;
            sat_r      <= sum_clipped;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            filter_r <= CTRL_RESET;
        else if (wr_control)
            filter_r <= w_byte_r[CTRL_FILTER_BIT];
    end

    assign signed_reading = signed_r;
    assign filter_enable  = filter_r;

    ////////////////////////////////////////////////////////////////////////////
    // Read views

    assign signed_remote_integer_bits   = signed_r[SIGNED_W-1:3];
    assign unsigned_remote_integer_bits = unsigned_r[UNSIGNED_W-1:5];

    // Masking at read time makes a filter change visible at once
    assign unsigned_remote_fraction_bits = unsigned_r[4:0]
        & (filter_r ? FRAC_FILT_MASK : FRAC_NOFILT_MASK);

    assign unsigned_low_byte = {unsigned_remote_fraction_bits,
                                {UNS_FRAC_LSB{1'b0}}};

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    assign ar_take = s_axi_arvalid & arready_r;
    assign ar_idx  = s_axi_araddr[AXI_ADDR_W-1:2];

    always_comb
    begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (ar_idx)
            IDX_SIGNED_HIGH:   rd_byte = signed_remote_integer_bits;
            IDX_OFFSET_HIGH:   rd_byte = offset_integer_bits;
            IDX_OFFSET_LOW:    rd_byte = offset_low_byte;
            IDX_UNSIGNED_HIGH: rd_byte = unsigned_remote_integer_bits;
            IDX_UNSIGNED_LOW:  rd_byte = unsigned_low_byte;
            IDX_CONTROL:       rd_byte = {7'h00, filter_r};
            IDX_STATUS:        rd_byte = {6'h00, sat_r, sampled_r};
            default:           rd_hit  = 1'b0;
        endcase
    end

    always_comb
    begin
        rvalid_nxt = rvalid_r;
        if (ar_take)
            rvalid_nxt = 1'b1;
        else if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
    end

    // One read in flight; arready stays low until the data is taken
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= '0;
        end
        else
        begin
            arready_r <= ~rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            if (ar_take)
            begin
                rdata_r <= {{(AXI_DATA_W-8){1'b0}}, rd_byte};
                rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

endmodule

// [remote_temp_pkg.sv]
package remote_temp_pkg;

    // Bus geometry
    localparam int AXI_ADDR_W = 12;
    localparam int AXI_DATA_W = 32;
    localparam int AXI_STRB_W = 4;
    localparam int IDX_W      = 10;

    // Register indexes; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_SIGNED_HIGH   = 10'h001;
    localparam logic [IDX_W-1:0] IDX_OFFSET_HIGH   = 10'h011;
    localparam logic [IDX_W-1:0] IDX_OFFSET_LOW    = 10'h012;
    localparam logic [IDX_W-1:0] IDX_UNSIGNED_HIGH = 10'h031;
    localparam logic [IDX_W-1:0] IDX_UNSIGNED_LOW  = 10'h032;
    localparam logic [IDX_W-1:0] IDX_CONTROL       = 10'h040;
    localparam logic [IDX_W-1:0] IDX_STATUS        = 10'h041;

    // Reading widths: signed is 8.3, unsigned is 8.5
    localparam int SIGNED_W   = 11;
    localparam int UNSIGNED_W = 13;
    localparam int SUM_W      = 12;

    // Field layout
    localparam logic [7:0] OFFSET_HIGH_RESET = 8'h00;
    localparam logic [7:0] OFFSET_LOW_RESET  = 8'h00;
    localparam logic [7:0] OFFSET_HIGH_MASK  = 8'hff;
    localparam logic [7:0] OFFSET_LOW_MASK   = 8'he0;
    localparam int         OFFSET_FRAC_LSB   = 5;
    localparam int         UNS_FRAC_LSB      = 3;
    localparam logic [4:0] FRAC_NOFILT_MASK  = 5'h1c;
    localparam logic [4:0] FRAC_FILT_MASK    = 5'h1f;
    localparam int         CTRL_FILTER_BIT   = 0;
    localparam logic       CTRL_RESET        = 1'b0;
    localparam int         STAT_SAMPLE_BIT   = 0;
    localparam int         STAT_SAT_BIT      = 1;

    // Saturation limits of the 11-bit signed reading
    localparam logic [SIGNED_W-1:0] SIGNED_MAX = 11'h3ff;
    localparam logic [SIGNED_W-1:0] SIGNED_MIN = 11'h400;

    // Responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [testbench.sv]
`timescale 1ns/1ps

module testbench;
    import remote_temp_pkg::*;
    logic clk_sys, reset, conv_valid, filter_enable;
    logic [SIGNED_W-1:0] conv_signed, signed_reading;
    logic [UNSIGNED_W-1:0] conv_unsigned;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int num_errors = 0;
    int tests_run = 0;

    remote_temp_offset_and_format dut_u (.clk_sys(clk_sys), .reset(reset),
        .conv_valid(conv_valid), .conv_signed(conv_signed), .conv_unsigned(conv_unsigned),
        .signed_reading(signed_reading), .filter_enable(filter_enable),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    conv_model conv_u (.clk_sys(clk_sys), .conv_valid(conv_valid),
        .conv_signed(conv_signed), .conv_unsigned(conv_unsigned));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 50);
        bready <= 1'b0;
        if (n >= 50) close_out_timeout();
        check("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 50);
        rready <= 1'b0;
        if (n >= 50) close_out_timeout();
        check("rresp", {30'h0, er}, {30'h0, rresp});
        check("rdata", ed, rdata);
    endtask

    task automatic close_out_timeout;
        num_errors++;
        close_out();
    endtask

    function automatic logic [10:0] exp_sum(input logic [7:0] hi, lo, input logic [10:0] c);
        logic signed [11:0] s;
        s = $signed({hi[7], hi, lo[7:5]}) + $signed({c[10], c});
        if (s > 12'sd1023) return 11'h3ff;
        if (s < -12'sd1024) return 11'h400;
        return s[10:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic t_offset_regs;
        axi_read(12'h044, 32'h0, RESP_OKAY);
        axi_read(12'h048, 32'h0, RESP_OKAY);
        axi_write(12'h044, 32'h0000_00a5, RESP_OKAY);
        axi_write(12'h048, 32'h0000_00ff, RESP_OKAY);
        axi_read(12'h044, 32'h0000_00a5, RESP_OKAY);
        axi_read(12'h048, 32'h0000_00e0, RESP_OKAY);
        // Second reset mid-run must clear the offset again
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        axi_read(12'h044, 32'h0, RESP_OKAY);
        axi_read(12'h048, 32'h0, RESP_OKAY);
    endtask

    task automatic t_offset_sum;
        logic [7:0] hi[5] = '{8'h01, 8'hfd, 8'hfd, 8'h7f, 8'h80};
        logic [7:0] lo[5] = '{8'h40, 8'h80, 8'h80, 8'he0, 8'h00};
        logic [10:0] cv[5] = '{11'h0cc, 11'h0cc, 11'h7f8, 11'h3f0, 11'h400};
        logic [10:0] e;
        for (int i = 0; i < 5; i++)
        begin
            e = exp_sum(hi[i], lo[i], cv[i]);
            axi_write(12'h044, {24'h0, hi[i]}, RESP_OKAY);
            axi_write(12'h048, {24'h0, lo[i] | 8'h1f}, RESP_OKAY);
            conv_u.sample(cv[i], 13'h0);
            // The capture lands in the strobe edge's update, so look one edge later
            @(posedge clk_sys);
            check("signed_reading", {21'h0, e}, {21'h0, signed_reading});
            axi_read(12'h004, {24'h0, e[10:3]}, RESP_OKAY);
            // Last two cases push the sum past either end, so the clip flag must be set
            axi_read(12'h104, {30'h0, (i > 2) ? 2'b11 : 2'b01}, RESP_OKAY);
        end
    endtask

    task automatic t_unsigned_format;
        logic [12:0] u[2] = '{13'h1235, 13'h1fff};
        for (int f = 0; f < 2; f++)
        begin
            axi_write(12'h100, f, RESP_OKAY);
            check("filter_enable", f, {31'h0, filter_enable});
            for (int i = 0; i < 2; i++)
            begin
                conv_u.sample(11'h0, u[i]);
                axi_read(12'h0c4, {24'h0, u[i][12:5]}, RESP_OKAY);
                axi_read(12'h0c8, {24'h0, u[i][4:2], f ? u[i][1:0] : 2'b00, 3'b000},
                         RESP_OKAY);
            end
        end
    endtask

    task automatic t_bus_errors;
        axi_read(12'h200, 32'h0, RESP_SLVERR);
        axi_write(12'h3fc, 32'h0000_0055, RESP_SLVERR);
        // Filter is still on and the last capture was all ones, so every fraction bit shows
        axi_write(12'h0c8, 32'h0000_00ff, RESP_OKAY);
        axi_read(12'h0c8, 32'h0000_00f8, RESP_OKAY);
    endtask

    initial
    begin
        reset = 1'b1;
        awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0; wvalid = 1'b0; bready = 1'b0;
        araddr = '0; arvalid = 1'b0; rready = 1'b0;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        t_offset_regs();
        t_offset_sum();
        t_unsigned_format();
        t_bus_errors();
        close_out();
    end
endmodule
